// *** inc/cic_pkg.sv ***
package cic_pkg;
	// ---------------------------------------------
	// Widths and fixed words
	// ---------------------------------------------
	localparam int          PCW      = 15;
	localparam int          SDEPTH   = 16;
	localparam logic [13:0] W_BRACC  = 14'h000B;
	localparam logic [13:0] W_CALACC = 14'h000A;
	localparam logic [13:0] W_ISRX   = 14'h0009;
	localparam logic [13:0] W_RET    = 14'h0008;
	localparam logic [13:0] W_WDT    = 14'h0064;
	localparam logic [13:0] W_OPT    = 14'h0062;
	localparam logic [13:0] W_RST    = 14'h0001;
	localparam logic [13:0] W_SLP    = 14'h0063;
	localparam logic [10:0] P_DIRL   = 11'h00C;
	localparam logic [10:0] P_IRD    = 11'h002;
	localparam logic [10:0] P_IWR    = 11'h003;
	localparam logic [4:0]  P_BRL    = 5'h19;
	localparam logic [2:0]  P_CALL   = 3'h4;
	localparam logic [2:0]  P_JMP    = 3'h5;
	localparam logic [5:0]  P_RETL   = 6'h34;
	localparam logic [6:0]  P_PADD   = 7'h62;
	localparam logic [6:0]  P_IRDX   = 7'h7E;
	localparam logic [6:0]  P_IWRX   = 7'h7F;
	localparam logic [5:0]  P_ANDL   = 6'h39;
	localparam logic [5:0]  P_ADDL   = 6'h3E;
	localparam logic [5:0]  P_ANDF   = 6'h05;
	localparam logic [5:0]  P_ADDF   = 6'h07;
	// ---------------------------------------------
	// Status bits and reset values
	// ---------------------------------------------
	localparam int          SB_C     = 0;
	localparam int          SB_DCY   = 1;
	localparam int          SB_Z     = 2;
	localparam int          SB_PWD   = 3;
	localparam int          SB_TMO   = 4;
	localparam logic [4:0]  STAT_RST = 5'h18;
	localparam logic [7:0]  OPT_RST  = 8'hFF;
	// ---------------------------------------------
	// Register port map
	// ---------------------------------------------
	localparam logic [7:0]  RA_CTRL  = 8'h00;
	localparam logic [7:0]  RA_STAT  = 8'h04;
	localparam logic [7:0]  RA_ACC   = 8'h08;
	localparam logic [7:0]  RA_FSR0  = 8'h0C;
	localparam logic [7:0]  RA_FSR1  = 8'h10;
	localparam logic [7:0]  RA_PC    = 8'h14;
	localparam logic [7:0]  RA_OPT   = 8'h18;
	localparam int          CB_RUN   = 0;
	localparam int          CB_WAKE  = 1;
	// ---------------------------------------------
	// Types
	// ---------------------------------------------
	typedef enum logic [4:0] {
		OP_IDLE = 5'b00000, OP_BRL  = 5'b00001, OP_BRACC = 5'b00010,
		OP_CALL = 5'b00011, OP_CALACC = 5'b00100, OP_JMP = 5'b00101,
		OP_ISRX = 5'b00110, OP_RETL = 5'b00111, OP_RET  = 5'b01000,
		OP_WDT  = 5'b01001, OP_OPT  = 5'b01010, OP_RST  = 5'b01011,
		OP_SLP  = 5'b01100, OP_DIRL = 5'b01101, OP_PADD = 5'b01110,
		OP_IRD  = 5'b01111, OP_IRDX = 5'b10000, OP_IWR  = 5'b10001,
		OP_IWRX = 5'b10010, OP_ANDL = 5'b10011, OP_ADDL = 5'b10100,
		OP_ANDF = 5'b10101, OP_ADDF = 5'b10110
	} cic_op_t;
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_FLUSH = 2'b01,
		ST_STALL = 2'b10,
		ST_SLEEP = 2'b11
	} cic_st_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        we;
		logic        re;
	} cic_dm_req_t;
endpackage : cic_pkg

// *** core/cic_core.sv ***
// Behaviour
// [RQ1] Fixed word: two-cycle branch by accumulator
// [RQ2] Fixed word: two-cycle call using accumulator
// [RQ3] Fixed word: two-cycle interrupt return
// [RQ4] Return loading literal into accumulator
// [RQ5] Fixed word: plain two-cycle return
// [RQ6] Watchdog clear sets timeout, powerdown flags
// [RQ7] Accumulator copied into option register
// [RQ8] Fixed word triggers software reset
// [RQ9] Standby entry, updating timeout, powerdown
// [RQ10] Accumulator loads selected pin direction
// [RQ11] Add 6-bit literal to pointer n
// [RQ12] Literal signed, full 16-bit pointer
// [RQ13] Pointer wraps; pointer add keeps flags
// [RQ14] Indirect read with modifier, zero flag
// [RQ15] Indexed indirect read, zero flag
// [RQ16] Indirect write with modifier, no flags
// [RQ17] Indexed indirect write, no flags
// [RQ18] PC-changing ops take two cycles
// [RQ19] Pointer MSb set adds one cycle
// [RQ20] AND immediate updates only zero
// [RQ21] ADD immediate updates carry, digit, zero
// [RQ22] File AND/ADD with destination bit
// [RQ23] Absolute jump and call, two cycles
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module cic_core
	import cic_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	input  wire logic [13:0] i_instr,
	input  wire logic [7:0]  i_dm_rdata,
	input  wire logic [7:0]  i_bus_addr,
	input  wire logic [15:0] i_bus_wdata,
	input  wire logic        i_bus_wr,
	input  wire logic        i_bus_rd,
	output logic      [15:0] o_bus_rdata,
	output logic      [14:0] o_pc,
	output var cic_dm_req_t  o_dm,
	output logic             o_dir_we,
	output logic      [2:0]  o_dir_sel,
	output logic      [7:0]  o_option,
	output logic             o_wdt_clr,
	output logic             o_sw_reset,
	output logic             o_sleep,
	output logic             o_isr_exit
);
	// ---------------------------------------------
	// State
	// ---------------------------------------------
	cic_st_t      st_r;
	logic         ph_r;
	logic         run_r;
	logic         xtra_r;
	logic [13:0]  ir_r;
	logic [7:0]   w_r;
	logic [4:0]   stat_r;
	logic [15:0]  fsr_r [2];
	logic [14:0]  pc_r;
	logic [14:0]  stk_r [SDEPTH];
	logic [3:0]   sp_r;
	logic [7:0]   opt_r;
	cic_dm_req_t  dm_r;
	logic         dir_we_r;
	logic [2:0]   dir_sel_r;
	logic         sleep_r;
	logic         wdt_r;
	logic         rst_r;
	logic         isrx_r;
	logic [15:0]  rdata_r;

	// ---------------------------------------------
	// Decode
	// ---------------------------------------------
	// Fixed words win over the direction-load range they sit in
	function automatic cic_op_t dec(input logic [13:0] w);
		cic_op_t o;
		o = OP_IDLE;
		if (w == W_BRACC)
			o = OP_BRACC;               // see [RQ1]
		else if (w == W_CALACC)
			o = OP_CALACC;              // see [RQ2]
		else if (w == W_ISRX)
			o = OP_ISRX;                // see [RQ3]
		else if (w == W_RET)
			o = OP_RET;                 // see [RQ5]
		else if (w == W_WDT)
			o = OP_WDT;                 // see [RQ6]
		else if (w == W_OPT)
			o = OP_OPT;                 // see [RQ7]
		else if (w == W_RST)
			o = OP_RST;                 // see [RQ8]
		else if (w == W_SLP)
			o = OP_SLP;                 // see [RQ9]
		else if (w[13:3] == P_DIRL)
			o = OP_DIRL;                // see [RQ10]
		else if (w[13:3] == P_IRD)
			o = OP_IRD;                 // see [RQ14]
		else if (w[13:3] == P_IWR)
			o = OP_IWR;                 // see [RQ16]
		else if (w[13:9] == P_BRL)
			o = OP_BRL;
		else if (w[13:11] == P_CALL)
			o = OP_CALL;                // see [RQ23]
		else if (w[13:11] == P_JMP)
			o = OP_JMP;                 // see [RQ23]
		else if (w[13:8] == P_RETL)
			o = OP_RETL;                // see [RQ4]
		else if (w[13:7] == P_PADD)
			o = OP_PADD;                // see [RQ11]
		else if (w[13:7] == P_IRDX)
			o = OP_IRDX;                // see [RQ15]
		else if (w[13:7] == P_IWRX)
			o = OP_IWRX;                // see [RQ17]
		else if (w[13:8] == P_ANDL)
			o = OP_ANDL;
		else if (w[13:8] == P_ADDL)
			o = OP_ADDL;
		else if (w[13:8] == P_ANDF)
			o = OP_ANDF;                // see [RQ22]
		else if (w[13:8] == P_ADDF)
			o = OP_ADDF;                // see [RQ22]
		return o;
	endfunction : dec

	cic_op_t      op_f;
	cic_op_t      op_e;
	logic         nf;
	logic         ne;
	logic         ind_f;
	logic [15:0]  ea_f;
	logic         adv;
	logic         exe;
	logic         two_cyc;

	// Fetch-side pointer choice and effective address
	always_comb
	begin
		op_f  = dec(i_instr);
		nf    = (op_f == OP_IRD || op_f == OP_IWR) ? i_instr[2] :
		        (op_f == OP_ANDF || op_f == OP_ADDF) ? i_instr[0] : i_instr[6];
		ind_f = 1'b0;
		ea_f  = {9'h000, i_instr[6:0]};
		case (op_f)
			OP_IRD, OP_IWR:
			begin
				ind_f = 1'b1;
				// Pre forms move first, post forms use the old value
				ea_f  = i_instr[1] ? fsr_r[nf] :
				        fsr_r[nf] + (i_instr[0] ? 16'hFFFF : 16'h0001); // see [RQ14]
			end
			OP_IRDX, OP_IWRX:
			begin
				ind_f = 1'b1;
				ea_f  = fsr_r[nf] + {{10{i_instr[5]}}, i_instr[5:0]}; // see [RQ15]
			end
			OP_ANDF, OP_ADDF:
			begin
				ind_f = (i_instr[6:1] == 6'h00);
				if (ind_f)
					ea_f = fsr_r[nf];
			end
			default:
				ind_f = 1'b0;
		endcase
	end

	// Execute-side decode and sequencing terms
	assign op_e    = dec(ir_r);
	assign ne      = (op_e == OP_IRD || op_e == OP_IWR) ? ir_r[2] : ir_r[6];
	assign adv     = run_r && st_r != ST_SLEEP;
	assign exe     = adv && ph_r && ((st_r == ST_RUN && !xtra_r) || st_r == ST_STALL);
	assign two_cyc = op_e inside {OP_BRL, OP_BRACC, OP_CALL, OP_CALACC, OP_JMP,
	                              OP_ISRX, OP_RETL, OP_RET}; // see [RQ18]

	// ---------------------------------------------
	// Arithmetic
	// ---------------------------------------------
	logic [7:0]   opnd;
	logic [8:0]   sum;
	logic [4:0]   nib;
	logic [7:0]   res;
	always_comb
	begin
		opnd = (op_e == OP_ANDF || op_e == OP_ADDF) ? i_dm_rdata : ir_r[7:0];
		sum  = {1'b0, w_r} + {1'b0, opnd};
		nib  = {1'b0, w_r[3:0]} + {1'b0, opnd[3:0]};
		case (op_e)
			OP_ANDL, OP_ANDF:
				res = w_r & opnd;        // see [RQ20]
			OP_ADDL, OP_ADDF:
				res = sum[7:0];          // see [RQ21]
			default:
				res = i_dm_rdata;
		endcase
	end

	// ---------------------------------------------
	// Sequencer
	// ---------------------------------------------
	// Two clocks per instruction cycle: fetch/address, then execute
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_r   <= ST_RUN;
			ph_r   <= 1'b0;
			xtra_r <= 1'b0;
			ir_r   <= 14'h0000;
			sleep_r <= 1'b0;
		end
		else if (st_r == ST_SLEEP)
		begin
			if (i_bus_wr && i_bus_addr == RA_CTRL && i_bus_wdata[CB_WAKE])
			begin
				st_r    <= ST_RUN;
				sleep_r <= 1'b0;
			end
			ph_r <= 1'b0;
		end
		else if (adv)
		begin
			ph_r <= !ph_r;
			if (!ph_r && st_r == ST_RUN)
			begin
				ir_r   <= i_instr;
				xtra_r <= ind_f && fsr_r[nf][15];  // see [RQ19]
			end
			if (ph_r)
			begin
				if (st_r == ST_RUN && xtra_r)
					st_r <= ST_STALL;               // see [RQ19]
				else if (exe && op_e == OP_SLP)
				begin
					st_r    <= ST_SLEEP;            // see [RQ9]
					sleep_r <= 1'b1;
				end
				else if (exe && two_cyc)
					st_r <= ST_FLUSH;               // see [RQ18]
				else
					st_r <= ST_RUN;
			end
		end
	end

	// ---------------------------------------------
	// Program counter and stack
	// ---------------------------------------------
	// Stack wraps silently on over- and underflow
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			pc_r <= 15'h0000;
			sp_r <= 4'h0;
		end
		else if (exe)
		begin
			case (op_e)
				OP_BRL:
					pc_r <= pc_r + 15'h0001 + {{6{ir_r[8]}}, ir_r[8:0]};
				OP_BRACC:
					pc_r <= pc_r + 15'h0001 + {7'h00, w_r};      // see [RQ1]
				OP_CALL, OP_CALACC:
				begin
					stk_r[sp_r] <= pc_r + 15'h0001;
					sp_r        <= sp_r + 4'h1;
					pc_r        <= (op_e == OP_CALL) ? {pc_r[14:11], ir_r[10:0]} :
					               {pc_r[14:8], w_r};              // see [RQ2]
				end
				OP_JMP:
					pc_r <= {pc_r[14:11], ir_r[10:0]};            // see [RQ23]
				OP_RET, OP_RETL, OP_ISRX:
				begin
					pc_r <= stk_r[sp_r - 4'h1];                   // see [RQ5]
					sp_r <= sp_r - 4'h1;
				end
				default:
					pc_r <= pc_r + 15'h0001;
			endcase
		end
	end

	// ---------------------------------------------
	// Accumulator and status
	// ---------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			w_r    <= 8'h00;
			stat_r <= STAT_RST;
		end
		else if (exe)
		begin
			case (op_e)
				OP_RETL:
					w_r <= ir_r[7:0];                              // see [RQ4]
				OP_IRD, OP_IRDX, OP_ANDL, OP_ADDL, OP_ANDF, OP_ADDF:
				begin
					if (!(op_e inside {OP_ANDF, OP_ADDF}) || !ir_r[7])
						w_r <= res;                                // see [RQ22]
					stat_r[SB_Z] <= (res == 8'h00);                // see [RQ14]
					if (op_e == OP_ADDL || op_e == OP_ADDF)
					begin
						stat_r[SB_C]  <= sum[8];                   // see [RQ21]
						stat_r[SB_DCY] <= nib[4];
					end
				end
				OP_WDT:
				begin
					stat_r[SB_TMO] <= 1'b1;                        // see [RQ6]
					stat_r[SB_PWD] <= 1'b1;
				end
				OP_SLP:
				begin
					stat_r[SB_TMO] <= 1'b1;                        // see [RQ9]
					stat_r[SB_PWD] <= 1'b0;
				end
				default:
					w_r <= w_r;
			endcase
		end
	end

	// ---------------------------------------------
	// Pointers
	// ---------------------------------------------
	// Sums are cut to 16 bits, so the pointer wraps
	for (genvar g = 0; g < 2; g++)
	begin : g_fsr
		always_ff @(posedge i_sys_clk or negedge i_nrst)
		begin
			if (!i_nrst)
				fsr_r[g] <= 16'h0000;
			else if (exe && ne == 1'(g))
			begin
				if (op_e == OP_PADD)
					fsr_r[g] <= fsr_r[g] + {{10{ir_r[5]}}, ir_r[5:0]}; // see [RQ12]
				else if (op_e == OP_IRD || op_e == OP_IWR)
					fsr_r[g] <= fsr_r[g] + (ir_r[0] ? 16'hFFFF : 16'h0001); // see [RQ13]
			end
		end
	end

	// ---------------------------------------------
	// Data memory port
	// ---------------------------------------------
	// Read stands in the execute clock, write in the next fetch clock
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			dm_r <= '0;
		else if (adv && !ph_r && st_r == ST_RUN)
		begin
			dm_r.addr <= ea_f;
			dm_r.re   <= op_f inside {OP_IRD, OP_IRDX, OP_ANDF, OP_ADDF};
			dm_r.we   <= 1'b0;
		end
		else if (exe)
		begin
			dm_r.re <= 1'b0;
			if (op_e == OP_IWR || op_e == OP_IWRX)
			begin
				dm_r.we    <= 1'b1;                                // see [RQ16]
				dm_r.wdata <= w_r;                                 // see [RQ17]
			end
			else if ((op_e == OP_ANDF || op_e == OP_ADDF) && ir_r[7])
			begin
				dm_r.we    <= 1'b1;                                // see [RQ22]
				dm_r.wdata <= res;
			end
			else if (op_e == OP_DIRL)
				dm_r.wdata <= w_r;                                 // see [RQ10]
		end
		else
			dm_r.we <= 1'b0;
	end

	// ---------------------------------------------
	// Side effects and pulses
	// ---------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			opt_r      <= OPT_RST;
			dir_we_r   <= 1'b0;
			dir_sel_r  <= 3'h0;
			wdt_r      <= 1'b0;
			rst_r      <= 1'b0;
			isrx_r     <= 1'b0;
		end
		else
		begin
			dir_we_r  <= exe && op_e == OP_DIRL;                   // see [RQ10]
			wdt_r     <= exe && op_e == OP_WDT;                    // see [RQ6]
			rst_r     <= exe && op_e == OP_RST;                    // see [RQ8]
			isrx_r    <= exe && op_e == OP_ISRX;                   // see [RQ3]
			if (exe && op_e == OP_DIRL)
				dir_sel_r <= ir_r[2:0];
			if (exe && op_e == OP_OPT)
				opt_r <= w_r;                                      // see [RQ7]
		end
	end

	// ---------------------------------------------
	// Register port
	// ---------------------------------------------
	// Run bit gates the sequencer; data stand one cycle only
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			run_r   <= 1'b1;
			rdata_r <= 16'h0000;
		end
		else
		begin
			if (i_bus_wr && i_bus_addr == RA_CTRL)
				run_r <= i_bus_wdata[CB_RUN];
			rdata_r <= 16'h0000;
			if (i_bus_rd)
			begin
				case (i_bus_addr)
					RA_CTRL: rdata_r <= {15'h0000, run_r};
					RA_STAT: rdata_r <= {11'h000, stat_r};
					RA_ACC:  rdata_r <= {8'h00, w_r};
					RA_FSR0: rdata_r <= fsr_r[0];
					RA_FSR1: rdata_r <= fsr_r[1];
					RA_PC:   rdata_r <= {1'b0, pc_r};
					RA_OPT:  rdata_r <= {8'h00, opt_r};
					default: rdata_r <= 16'h0000;
				endcase
			end
		end
	end

	assign o_bus_rdata = rdata_r;
	assign o_pc        = pc_r;
	assign o_dm        = dm_r;
	assign o_dir_we    = dir_we_r;
	assign o_dir_sel   = dir_sel_r;
	assign o_option    = opt_r;
	assign o_wdt_clr   = wdt_r;
	assign o_sw_reset  = rst_r;
	assign o_sleep     = sleep_r;
	assign o_isr_exit  = isrx_r;

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	brw_target_a: assert property (exe && op_e == OP_BRACC |=> pc_r == $past(pc_r) + 15'h0001 + {7'h00, $past(w_r)}) // see [RQ1]
		else $error("branch by accumulator target wrong");
	sub_invoke_acc_push_a: assert property (exe && op_e == OP_CALACC |=> sp_r == $past(sp_r) + 4'h1 && pc_r[7:0] == $past(w_r)) // see [RQ2]
		else $error("call by accumulator wrong");
	isr_exit_a: assert property (exe && op_e == OP_ISRX |=> o_isr_exit ##1 !o_isr_exit) // see [RQ3]
		else $error("interrupt return pulse wrong");
	retl_load_a: assert property (exe && op_e == OP_RETL |=> w_r == $past(ir_r[7:0]) && sp_r == $past(sp_r) - 4'h1) // see [RQ4]
		else $error("literal return wrong");
	wdt_flags_a: assert property (exe && op_e == OP_WDT |=> o_wdt_clr && stat_r[SB_TMO] && stat_r[SB_PWD]) // see [RQ6]
		else $error("watchdog clear flags wrong");
	sleep_entry_a: assert property (exe && op_e == OP_SLP |=> o_sleep && stat_r[SB_TMO] && !stat_r[SB_PWD]) // see [RQ9]
		else $error("standby entry wrong");
	option_load_a: assert property (exe && op_e == OP_OPT |=> o_option == $past(w_r)) // see [RQ7]
		else $error("option load wrong");
	padd_flags_a: assert property (exe && op_e == OP_PADD |=> $stable(stat_r)) // see [RQ13]
		else $error("pointer add changed flags");
	flush_cycle_a: assert property (exe && two_cyc |=> st_r == ST_FLUSH && !dm_r.re ##2 st_r == ST_RUN) // see [RQ18]
		else $error("second cycle missing");
	stall_cycle_a: assert property (adv && ph_r && st_r == ST_RUN && xtra_r |=> st_r == ST_STALL && pc_r == $past(pc_r)) // see [RQ19]
		else $error("extra cycle missing");
	andl_zero_a: assert property (exe && op_e == OP_ANDL |=> stat_r[SB_Z] == ($past(w_r & ir_r[7:0]) == 8'h00) && $stable(stat_r[SB_C])) // see [RQ20]
		else $error("and immediate flags wrong");

	call_seen_c: cover property (exe && op_e == OP_CALL ##[1:8] exe && op_e == OP_RET);
	stall_seen_c: cover property (st_r == ST_STALL ##2 exe);
	sleep_wake_c: cover property (o_sleep ##[1:20] !o_sleep);
endmodule : cic_core
`default_nettype wire

// *** test/cic_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------
// Program and data memory facing the core
// ---------------------------------------------
module cic_mem
	import cic_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic [14:0] i_pc,
	input  var cic_dm_req_t  i_dm,
	output logic      [13:0] o_instr,
	output logic      [7:0]  o_rdata
);
	logic [13:0] rom [0:63];
	logic [7:0]  ram [0:255];
	logic [7:0]  last_r = 8'hA5;

	// Fetch is combinational, the word stands with the address
	assign o_instr = rom[i_pc[5:0]];
	// Idle read lines show the inverse of the last value, so stale data never matches
	assign o_rdata = i_dm.re ? ram[i_dm.addr[7:0]] : ~last_r;

	// Write pulse lands at the edge that ends it
	always @(posedge i_sys_clk)
	begin
		if (i_dm.we === 1'b1)
			ram[i_dm.addr[7:0]] <= i_dm.wdata;
		if (i_dm.re === 1'b1)
			last_r <= ram[i_dm.addr[7:0]];
	end
endmodule : cic_mem
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("ERROR t=%0t mismatch got %h exp %h", $time, got, exp); \
		end \
	end
module testbench;
	import cic_pkg::*;
	logic        i_sys_clk;
	logic        i_nrst;
	logic [13:0] i_instr;
	logic [7:0]  i_dm_rdata;
	logic [7:0]  i_bus_addr;
	logic [15:0] i_bus_wdata;
	logic        i_bus_wr;
	logic        i_bus_rd;
	logic [15:0] o_bus_rdata;
	logic [14:0] o_pc;
	cic_dm_req_t o_dm;
	logic        o_dir_we;
	logic [2:0]  o_dir_sel;
	logic [7:0]  o_option;
	logic        o_wdt_clr;
	logic        o_sw_reset;
	logic        o_sleep;
	logic        o_isr_exit;
	int          num_errors = 0;
	int          n_compared = 0;
	int          n_dir, n_wdt, n_rst, n_isr;
	logic [2:0]  dir_sel;
	logic [7:0]  dir_data;
	logic [14:0] end_pc;
	int          t, off;

	cic_core u_cic_core (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_instr(i_instr), .i_dm_rdata(i_dm_rdata),
		.i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd),
		.o_bus_rdata(o_bus_rdata), .o_pc(o_pc), .o_dm(o_dm), .o_dir_we(o_dir_we), .o_dir_sel(o_dir_sel),
		.o_option(o_option), .o_wdt_clr(o_wdt_clr), .o_sw_reset(o_sw_reset), .o_sleep(o_sleep),
		.o_isr_exit(o_isr_exit));
	cic_mem u_cic_mem (.i_sys_clk(i_sys_clk), .i_pc(o_pc), .i_dm(o_dm), .o_instr(i_instr), .o_rdata(i_dm_rdata));

	// ---------------------------------------------
	// Clock, pulse monitor, watchdog
	// ---------------------------------------------
	initial
	begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// Side pulses last one clock, so each high sample is one event
	always @(posedge i_sys_clk)
	begin
		if (o_dir_we === 1'b1)
		begin
			n_dir++;
			dir_sel = o_dir_sel;
			dir_data = o_dm.wdata;
		end
		n_wdt += int'(o_wdt_clr === 1'b1);
		n_rst += int'(o_sw_reset === 1'b1);
		n_isr += int'(o_isr_exit === 1'b1);
	end
	// Whole run is a few hundred clocks; far beyond that means a hang
	initial
	begin
		#100us;
		num_errors++;
		end_of_test();
	end

	// ---------------------------------------------
	// Tasks
	// ---------------------------------------------
	task automatic end_of_test();
		if (num_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_bus_addr  <= a;
		i_bus_wdata <= d;
		i_bus_wr    <= 1'b1;
		@(posedge i_sys_clk);
		i_bus_wr    <= 1'b0;
	endtask : bus_wr
	// Read data stand only in the cycle after the strobe
	task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
		@(posedge i_sys_clk);
		i_bus_addr <= a;
		i_bus_rd   <= 1'b1;
		@(posedge i_sys_clk);
		i_bus_rd   <= 1'b0;
		#1 `CHK(o_bus_rdata, exp)
	endtask : chk_reg
	// Program loaded under reset, a self jump closes it
	task automatic boot(input logic [13:0] q[$]);
		@(posedge i_sys_clk);
		i_nrst <= 1'b0;
		foreach (u_cic_mem.rom[i])
			u_cic_mem.rom[i] = 14'h0000;
		foreach (q[i])
			u_cic_mem.rom[i] = q[i];
		end_pc = 15'(q.size());
		u_cic_mem.rom[q.size()] = 14'h2800 | 14'(q.size());
		n_dir = 0;
		n_wdt = 0;
		n_rst = 0;
		n_isr = 0;
		repeat (16) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
	endtask : boot
	task automatic wait_end(output int n);
		n = 0;
		do
		begin
			@(posedge i_sys_clk);
			n++;
		end
		while (o_pc !== end_pc && n < 2000);
		// A program that never reaches its end is a failure
		if (n >= 2000)
			num_errors++;
	endtask : wait_end

	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial
	begin
		i_nrst = 1'b0;
		i_bus_addr = 8'h00;
		i_bus_wdata = 16'h0000;
		i_bus_wr = 1'b0;
		i_bus_rd = 1'b0;
		u_cic_mem.ram[8'h15] = 8'h00;
		u_cic_mem.ram[8'h20] = 8'hF1;
		u_cic_mem.ram[8'h21] = 8'h3C;
		// Idle run fixes the start offset for later timing checks
		boot('{14'h0000, 14'h0000, 14'h0000, 14'h0000});
		wait_end(t);
		off = t - 8;
		chk_reg(RA_CTRL, 16'h0001);
		chk_reg(RA_STAT, 16'h0018);
		chk_reg(RA_OPT, 16'h00FF);
		chk_reg(8'h1C, 16'h0000);
		// Literal and file arithmetic with flags
		boot('{14'h3E9F, 14'h3E71, 14'h390F, 14'h3E0F, 14'h07A0, 14'h0521});
		wait_end(t);
		`CHK(t, off + 12)
		bus_wr(RA_ACC, 16'hFFFF);
		chk_reg(RA_ACC, 16'h000C);
		chk_reg(RA_STAT, 16'h001B);
		`CHK(u_cic_mem.ram[8'h20], 8'h00)
		`CHK(u_cic_mem.ram[8'h21], 8'h3C)
		// Pointer adds wrapping both ways
		boot('{14'h313F, 14'h315F, 14'h3160, 14'h3141});
		wait_end(t);
		`CHK(t, off + 8)
		chk_reg(RA_FSR0, 16'hFFFF);
		chk_reg(RA_FSR1, 16'h0000);
		chk_reg(RA_STAT, 16'h0018);
		// Indirect moves with modifiers and offsets
		boot('{14'h3E5A, 14'h3110, 14'h001A, 14'h3900, 14'h0011, 14'h3F83, 14'h3F05});
		wait_end(t);
		`CHK(t, off + 14)
		`CHK(u_cic_mem.ram[8'h10], 8'h5A)
		chk_reg(RA_FSR0, 16'h0010);
		`CHK(u_cic_mem.ram[8'h13], 8'h5A)
		chk_reg(RA_ACC, 16'h0000);
		chk_reg(RA_STAT, 16'h001C);
		// Pointer with top bit set costs a stall cycle
		boot('{14'h3E66, 14'h317F, 14'h001C});
		wait_end(t);
		`CHK(t, off + 8)
		chk_reg(RA_FSR1, 16'h0000);
		`CHK(u_cic_mem.ram[8'h00], 8'h66)
		// Branch, calls and returns, each two instruction cycles
		boot('{14'h3E02, 14'h000B, 14'h3E40, 14'h3E40, 14'h2008, 14'h000A, 14'h280E, 14'h0000,
			14'h340B, 14'h0000, 14'h0000, 14'h3E10, 14'h0008, 14'h0000, 14'h0000});
		wait_end(t);
		`CHK(t, off + 30)
		chk_reg(RA_ACC, 16'h001B);
		chk_reg(RA_STAT, 16'h0018);
		// Inherent ops, standby and wake
		boot('{14'h3E37, 14'h0062, 14'h0065, 14'h0063, 14'h0064, 14'h0001, 14'h2008, 14'h2809, 14'h0009, 14'h0000});
		t = 0;
		while (o_sleep !== 1'b1 && t < 200)
		begin
			@(posedge i_sys_clk);
			t++;
		end
		if (t >= 200)
			num_errors++;
		`CHK(o_option, 8'h37)
		chk_reg(RA_OPT, 16'h0037);
		`CHK(n_dir, 1)
		`CHK(dir_sel, 3'h5)
		`CHK(dir_data, 8'h37)
		chk_reg(RA_STAT, 16'h0010);
		bus_wr(RA_CTRL, 16'h0003);
		wait_end(t);
		`CHK(o_sleep, 1'b0)
		chk_reg(RA_STAT, 16'h0018);
		`CHK(n_wdt, 1)
		`CHK(n_rst, 1)
		`CHK(n_isr, 1)
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
